// File: verilog/nco_pkg.sv
// Shared constants for the oscillator phase, timer and sine/cosine block.
package nco_pkg;

  // Widths of the host word, the accumulators and the lookup address.
  localparam int CMD_W = 16;
  localparam int ACC_W = 32;
  localparam int LUT_ADDR_W = 20;
  localparam int QPSK_ZERO_W = 14;

  // Write port register select codes; code 2'h3 is reserved.
  localparam logic [1:0] SEL_FREQ_LOW = 2'h0;
  localparam logic [1:0] SEL_FREQ_HIGH = 2'h1;
  localparam logic [1:0] SEL_PHASE = 2'h2;

  // Values after reset.
  localparam logic [CMD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [ACC_W-1:0] ACC_RESET = 32'h00000000;

  // Symmetric full scale of the sine and cosine words.
  localparam logic signed [15:0] FULL_POS = 16'sh7fff;
  localparam logic signed [15:0] FULL_NEG = 16'sh8001;

  // Rotation pipeline: stages, datapath width, angle width, guard bits.
  localparam int CORDIC_N = 16;
  localparam int CORDIC_W = 20;
  localparam int ANGLE_W = 22;
  localparam int GUARD_W = 2;

  // Start vector: full scale with guard bits, divided by the rotation gain.
  localparam logic signed [CORDIC_W-1:0] CORDIC_X0 = 20'sh136e8;
  localparam logic signed [CORDIC_W-1:0] CORDIC_ROUND = 20'sh00002;

  // Arctangent of 2^-i; a full circle is 2^22 angle units.
  localparam logic [ANGLE_W-1:0] ATAN_TABLE [0:CORDIC_N-1] = '{
    22'h080000, 22'h04b902, 22'h027ece, 22'h014445,
    22'h00a2c3, 22'h005176, 22'h0028be, 22'h00145f,
    22'h000a30, 22'h000518, 22'h00028c, 22'h000146,
    22'h0000a3, 22'h000051, 22'h000029, 22'h000014
  };

endpackage

// File: verilog/cordic_stage.sv
// One pipelined rotation stage of the sine/cosine generator.
`timescale 1ns/10ps
module cordic_stage
  import nco_pkg::*;
#(
  parameter int IDX = 0,
  parameter logic [ANGLE_W-1:0] ATAN = 22'h000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [CORDIC_W-1:0] x_in,
  input wire logic signed [CORDIC_W-1:0] y_in,
  input wire logic signed [ANGLE_W-1:0] z_in,
  input wire logic [1:0] quad_in,
  output logic signed [CORDIC_W-1:0] x_out,
  output logic signed [CORDIC_W-1:0] y_out,
  output logic signed [ANGLE_W-1:0] z_out,
  output logic [1:0] quad_out
);

  wire logic signed [CORDIC_W-1:0] x_sh = x_in >>> IDX;
  wire logic signed [CORDIC_W-1:0] y_sh = y_in >>> IDX;
  wire logic up = ~z_in[ANGLE_W-1];
  wire logic signed [CORDIC_W-1:0] next_x = up ? x_in - y_sh : x_in + y_sh;
  wire logic signed [CORDIC_W-1:0] next_y = up ? y_in + x_sh : y_in - x_sh;
  wire logic signed [ANGLE_W-1:0] next_z = up ? z_in - $signed(ATAN) : z_in + $signed(ATAN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_out <= '0;
      y_out <= '0;
      z_out <= '0;
      quad_out <= 2'h0;
    end else begin
      x_out <= next_x;
      y_out <= next_y;
      z_out <= next_z;
      quad_out <= quad_in;
    end
  end

endmodule // cordic_stage

// File: verilog/nco_phase_freq_sincos.sv
// Phase and frequency control, interval timer and sine/cosine generator.
`timescale 1ns/10ps
module nco_phase_freq_sincos
  import nco_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CHIP_SELECT_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [1:0] REGISTER_SELECT,
  input wire logic [CMD_W-1:0] COMMAND_WORD_BUS,
  input wire logic CENTER_FREQ_LOAD_EN_N,
  input wire logic OFFSET_FREQ_LOAD_EN_N,
  input wire logic PHASE_LOAD_EN_N,
  input wire logic PHASE_SOURCE_SELECT,
  input wire logic [1:0] QPSK_SYMBOL,
  input wire logic OFFSET_FREQ_GATE_N,
  input wire logic PHASE_ACC_PRESET_N,
  input wire logic PHASE_RANGE_SELECT,
  input wire logic TIMER_STEP_LOAD_EN_N,
  input wire logic TIMER_RESTART_BYPASS_N,
  output logic PHASE_CARRY_N,
  output logic TIMER_CARRY_N,
  output logic [15:0] SIN_OUT,
  output logic [15:0] COS_OUT
);

  // Reset release through two flip-flops.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Write port decode.
  // host write strobe
  wire logic wr_active = ~CHIP_SELECT_N & ~WRITE_STROBE_N;
  wire logic wr_low = wr_active & (REGISTER_SELECT == SEL_FREQ_LOW);
  wire logic wr_high = wr_active & (REGISTER_SELECT == SEL_FREQ_HIGH);
  wire logic wr_phase = wr_active & (REGISTER_SELECT == SEL_PHASE);

  logic [CMD_W-1:0] freq_input_low;
  logic [CMD_W-1:0] freq_input_high;
  logic [CMD_W-1:0] phase_input;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      freq_input_low <= WORD_RESET;
      freq_input_high <= WORD_RESET;
      phase_input <= WORD_RESET;
    end else begin
      if (wr_low) begin
        freq_input_low <= COMMAND_WORD_BUS;
      end
      if (wr_high) begin
        freq_input_high <= COMMAND_WORD_BUS;
      end
      if (wr_phase) begin
        phase_input <= COMMAND_WORD_BUS;
      end
    end
  end

  wire logic [ACC_W-1:0] load_word = {freq_input_high, freq_input_low};

  // Registered load enables; reset to the inactive level.
  logic center_freq_load_en_q;
  logic offset_freq_load_en_q;
  logic phase_load_en_q;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      center_freq_load_en_q <= 1'b1;
      offset_freq_load_en_q <= 1'b1;
      phase_load_en_q <= 1'b1;
    end else begin
      center_freq_load_en_q <= CENTER_FREQ_LOAD_EN_N;
      offset_freq_load_en_q <= OFFSET_FREQ_LOAD_EN_N;
      phase_load_en_q <= PHASE_LOAD_EN_N;
    end
  end

  logic [ACC_W-1:0] center_freq;
  logic [ACC_W-1:0] offset_freq;
  logic [ACC_W-1:0] time_step;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      center_freq <= ACC_RESET;
      offset_freq <= ACC_RESET;
    end else begin
      if (!center_freq_load_en_q) begin
        center_freq <= load_word;
      end
      if (!offset_freq_load_en_q) begin
        offset_freq <= load_word;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      time_step <= ACC_RESET;
    end else if (!TIMER_STEP_LOAD_EN_N) begin
      time_step <= load_word;
    end
  end

  // The symbol map is Gray coded so that 2'h2 lands on 270 degrees.
  // symbol phase map
  wire logic [1:0] qpsk_top = {QPSK_SYMBOL[1], QPSK_SYMBOL[1] ^ QPSK_SYMBOL[0]};
  wire logic [CMD_W-1:0] next_phase = PHASE_SOURCE_SELECT ? phase_input
                                      : {qpsk_top, {QPSK_ZERO_W{1'b0}}};

  logic [CMD_W-1:0] phase_reg;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= WORD_RESET;
    end else if (!phase_load_en_q) begin
      phase_reg <= next_phase;
    end
  end

  wire logic [ACC_W-1:0] offset_term = OFFSET_FREQ_GATE_N ? offset_freq : ACC_RESET;
  wire logic [ACC_W-1:0] phase_step = center_freq + offset_term;

  logic [ACC_W-1:0] phase_acc;
  logic [ACC_W-1:0] time_acc;
  logic phase_ovf;
  logic time_ovf;

  wire logic [ACC_W-1:0] phase_fb = PHASE_ACC_PRESET_N ? phase_acc : ACC_RESET;
  wire logic [ACC_W-1:0] time_fb = TIMER_RESTART_BYPASS_N ? time_acc : ACC_RESET;
  wire logic [ACC_W:0] phase_sum = {1'b0, phase_fb} + {1'b0, phase_step};
  wire logic [ACC_W:0] time_sum = {1'b0, time_fb} + {1'b0, time_step};

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase_acc <= ACC_RESET;
      time_acc <= ACC_RESET;
      phase_ovf <= 1'b0;
      time_ovf <= 1'b0;
    end else begin
      phase_acc <= phase_sum[ACC_W-1:0];
      time_acc <= time_sum[ACC_W-1:0];
      phase_ovf <= phase_sum[ACC_W];
      time_ovf <= time_sum[ACC_W];
    end
  end

  assign PHASE_CARRY_N = ~phase_ovf;
  assign TIMER_CARRY_N = ~time_ovf;

  wire logic [CMD_W-1:0] top_sum = phase_acc[ACC_W-1:CMD_W] + phase_reg;
  // half circle clears the top bit
  wire logic arg_msb = top_sum[CMD_W-1] & ~PHASE_RANGE_SELECT;
  wire logic [ACC_W-1:0] next_arg = {arg_msb, top_sum[CMD_W-2:0], phase_acc[CMD_W-1:0]};

  logic [ACC_W-1:0] phase_arg;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase_arg <= ACC_RESET;
    end else begin
      phase_arg <= next_arg;
    end
  end

  wire logic [LUT_ADDR_W-1:0] lut_addr = phase_arg[ACC_W-1:ACC_W-LUT_ADDR_W];
  wire logic [1:0] quad0 = lut_addr[LUT_ADDR_W-1:LUT_ADDR_W-2];
  wire logic signed [ANGLE_W-1:0] z0 = {2'b00, lut_addr[LUT_ADDR_W-3:0], 2'b00};

  // The rotation pipeline replaces a full table, trading latency for area.
  logic signed [CORDIC_W-1:0] cx [0:CORDIC_N];
  logic signed [CORDIC_W-1:0] cy [0:CORDIC_N];
  logic signed [ANGLE_W-1:0] cz [0:CORDIC_N];
  logic [1:0] cq [0:CORDIC_N];

  assign cx[0] = CORDIC_X0;
  assign cy[0] = '0;
  assign cz[0] = z0;
  assign cq[0] = quad0;

  genvar g;
  generate
    for (g = 0; g < CORDIC_N; g++) begin : g_stage
      cordic_stage #(
        .IDX(g),
        .ATAN(ATAN_TABLE[g])
      ) u_stage (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .x_in(cx[g]),
        .y_in(cy[g]),
        .z_in(cz[g]),
        .quad_in(cq[g]),
        .x_out(cx[g+1]),
        .y_out(cy[g+1]),
        .z_out(cz[g+1]),
        .quad_out(cq[g+1])
      );
    end
  endgenerate

  // Drop guard bits with rounding and clamp to the symmetric range.
  function automatic logic signed [15:0] sat16(input logic signed [CORDIC_W-1:0] v);
    logic signed [CORDIC_W-1:0] r;
    r = (v + CORDIC_ROUND) >>> GUARD_W;
    if (r > $signed({{(CORDIC_W-16){1'b0}}, FULL_POS})) begin
      sat16 = FULL_POS;
    end else if (r < $signed({{(CORDIC_W-16){1'b1}}, FULL_NEG})) begin
      sat16 = FULL_NEG;
    end else begin
      sat16 = r[15:0];
    end
  endfunction

  wire logic signed [15:0] c_res = sat16(cx[CORDIC_N]);
  wire logic signed [15:0] s_res = sat16(cy[CORDIC_N]);

  // Negation is safe because 8000 never reaches this point.
  logic signed [15:0] cos_q;
  logic signed [15:0] sin_q;

  always_comb begin
    case (cq[CORDIC_N])
      2'h0: begin
        cos_q = c_res;
        sin_q = s_res;
      end
      2'h1: begin
        cos_q = -s_res;
        sin_q = c_res;
      end
      2'h2: begin
        cos_q = -c_res;
        sin_q = -s_res;
      end
      2'h3: begin
        cos_q = s_res;
        sin_q = -c_res;
      end
      default: begin
        cos_q = c_res;
        sin_q = s_res;
      end
    endcase
  end

  wire logic [15:0] next_sin = TIMER_RESTART_BYPASS_N ? sin_q : phase_arg[ACC_W-1:CMD_W];
  wire logic [15:0] next_cos = TIMER_RESTART_BYPASS_N ? cos_q : phase_arg[CMD_W-1:0];

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      SIN_OUT <= WORD_RESET;
      COS_OUT <= WORD_RESET;
    end else begin
      SIN_OUT <= next_sin;
      COS_OUT <= next_cos;
    end
  end

endmodule // nco_phase_freq_sincos

// File: tb/nco_phase_freq_sincos_sva.sv
// Port checks for the phase, timer and sine/cosine block.
`timescale 1ns/10ps
module nco_phase_freq_sincos_sva (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CENTER_FREQ_LOAD_EN_N,
  input wire logic OFFSET_FREQ_LOAD_EN_N,
  input wire logic PHASE_LOAD_EN_N,
  input wire logic PHASE_SOURCE_SELECT,
  input wire logic [1:0] QPSK_SYMBOL,
  input wire logic OFFSET_FREQ_GATE_N,
  input wire logic PHASE_ACC_PRESET_N,
  input wire logic PHASE_RANGE_SELECT,
  input wire logic TIMER_RESTART_BYPASS_N,
  input wire logic PHASE_CARRY_N,
  input wire logic TIMER_CARRY_N,
  input wire logic [15:0] SIN_OUT,
  input wire logic [15:0] COS_OUT
);
  logic [3:0] calm;
  logic calm_now;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  function automatic logic [1:0] quad(input logic [1:0] q);
    return {q[1], q[1] ^ q[0]};
  endfunction
  // Static step with the symbol as the only phase source; the pipeline needs ten edges to settle.
  assign calm_now = !PHASE_ACC_PRESET_N && !TIMER_RESTART_BYPASS_N && !PHASE_RANGE_SELECT && !PHASE_SOURCE_SELECT
    && !PHASE_LOAD_EN_N && CENTER_FREQ_LOAD_EN_N && OFFSET_FREQ_LOAD_EN_N && !OFFSET_FREQ_GATE_N;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      calm <= 4'h0;
    end else begin
      calm <= !calm_now ? 4'h0 : (calm == 4'hf ? calm : calm + 4'h1);
    end
  end
  // Bypass may pass a raw 8000, so symmetry is only checked off bypass.
  chk_sin_symm: assert property (TIMER_RESTART_BYPASS_N [*2] |-> SIN_OUT != 16'h8000)
    else $error("sine output at 8000");
  chk_cos_symm: assert property (TIMER_RESTART_BYPASS_N [*2] |-> COS_OUT != 16'h8000)
    else $error("cosine output at 8000");
  chk_half_range: assert property ((!TIMER_RESTART_BYPASS_N && PHASE_RANGE_SELECT) [*3] |-> !SIN_OUT[15])
    else $error("half circle phase has top bit set");
  chk_timer_quiet: assert property (!TIMER_RESTART_BYPASS_N [*2] |-> TIMER_CARRY_N)
    else $error("timer carry while restart held");
  chk_phase_quiet: assert property (!PHASE_ACC_PRESET_N [*2] |-> PHASE_CARRY_N)
    else $error("phase carry while preset held");
  chk_steady_out: assert property (($stable(QPSK_SYMBOL) && calm > 4'h9) [*4] |-> $stable(SIN_OUT) && $stable(COS_OUT))
    else $error("preset accumulator output moved");
  chk_cos_hold: assert property (calm > 4'h9 |-> $stable(COS_OUT))
    else $error("low phase word moved with the symbol");
  chk_qpsk_shift: assert property (calm > 4'h9 |->
    SIN_OUT == $past(SIN_OUT) + {quad($past(QPSK_SYMBOL, 3)) - quad($past(QPSK_SYMBOL, 4)), 14'h0000})
    else $error("symbol change gave wrong phase shift");
  cover property (!PHASE_CARRY_N);
  cover property (!TIMER_CARRY_N);
  cover property (calm == 4'hf);
  cover property (PHASE_RANGE_SELECT && !TIMER_RESTART_BYPASS_N);
endmodule // nco_phase_freq_sincos_sva
bind nco_phase_freq_sincos nco_phase_freq_sincos_sva i_nco_phase_freq_sincos_sva (.SYS_CLK, .ARST_N,
  .CENTER_FREQ_LOAD_EN_N, .OFFSET_FREQ_LOAD_EN_N, .PHASE_LOAD_EN_N, .PHASE_SOURCE_SELECT, .QPSK_SYMBOL,
  .OFFSET_FREQ_GATE_N, .PHASE_ACC_PRESET_N, .PHASE_RANGE_SELECT, .TIMER_RESTART_BYPASS_N, .PHASE_CARRY_N,
  .TIMER_CARRY_N, .SIN_OUT, .COS_OUT);

// File: tb/nco_host_model.sv
// Host model that drives the parallel write port.
`timescale 1ns/10ps
module nco_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic wr_n,
  output logic [1:0] sel,
  output logic [15:0] data
);
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    sel = 2'h0;
    data = 16'h0000;
  end
  // single strobed write
  // A released bus shows the inverted word, so a late sample cannot match by luck.
  task automatic write(input logic [1:0] s, input logic [15:0] d, input logic sel_n);
    @(posedge clk);
    cs_n <= sel_n;
    wr_n <= 1'b0;
    sel <= s;
    data <= d;
    @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    data <= ~d;
  endtask
endmodule // nco_host_model

// File: tb/test_nco_phase_freq_sincos.sv
// Self-checking bench for the phase, timer and sine/cosine block.
`timescale 1ns/10ps
module test_nco_phase_freq_sincos import nco_pkg::*;;
  logic clk, arst_n, cs_n, wr_n, center_n, offset_n, phload_n, src, gate_n, preset_n, half, tstep_n, bypass_n;
  logic pcarry_n, tcarry_n;
  logic [1:0] sel, qpsk;
  logic [CMD_W-1:0] data, sin_out, cos_out;
  logic [15:0] shift_q [4] = '{16'h0000, 16'h4000, 16'hc000, 16'h8000};
  logic [15:0] sin_q [3] = '{16'h0000, FULL_POS, FULL_NEG};
  logic [15:0] cos_q [3] = '{FULL_POS, 16'h0000, 16'h0000};
  int fails, checks, n;
  nco_host_model i_nco_host_model (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .sel(sel), .data(data));
  nco_phase_freq_sincos i_nco_phase_freq_sincos (.SYS_CLK(clk), .ARST_N(arst_n), .CHIP_SELECT_N(cs_n),
    .WRITE_STROBE_N(wr_n), .REGISTER_SELECT(sel), .COMMAND_WORD_BUS(data), .CENTER_FREQ_LOAD_EN_N(center_n),
    .OFFSET_FREQ_LOAD_EN_N(offset_n), .PHASE_LOAD_EN_N(phload_n), .PHASE_SOURCE_SELECT(src), .QPSK_SYMBOL(qpsk),
    .OFFSET_FREQ_GATE_N(gate_n), .PHASE_ACC_PRESET_N(preset_n), .PHASE_RANGE_SELECT(half),
    .TIMER_STEP_LOAD_EN_N(tstep_n), .TIMER_RESTART_BYPASS_N(bypass_n), .PHASE_CARRY_N(pcarry_n),
    .TIMER_CARRY_N(tcarry_n), .SIN_OUT(sin_out), .COS_OUT(cos_out));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_of_test();
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, ref logic [15:0] got, input int tol = 0);
    int d;
    #1;
    d = $signed(got) - $signed(exp);
    checks++;
    if ($isunknown(got) || d > tol || d < -tol || (tol > 0 && got === 16'h8000)) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
    @(posedge clk);
  endtask
  task automatic load(input logic [31:0] w, input int which);
    i_nco_host_model.write(SEL_FREQ_LOW, w[15:0], 1'b0);
    i_nco_host_model.write(SEL_FREQ_HIGH, w[31:16], 1'b0);
    if (which == 0) center_n <= 1'b0;
    else if (which == 1) offset_n <= 1'b0;
    else tstep_n <= 1'b0;
    @(posedge clk);
    center_n <= 1'b1;
    offset_n <= 1'b1;
    tstep_n <= 1'b1;
    tick(8);
  endtask
  task automatic count_low(input logic tmr, input logic [15:0] exp);
    logic [15:0] lows;
    lows = 16'h0000;
    repeat (32) begin
      @(posedge clk);
      #1;
      if ((tmr ? tcarry_n : pcarry_n) === 1'b0) lows++;
    end
    chk("carry lows", exp, lows);
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    end_of_test();
  end
  initial begin
    {arst_n, center_n, offset_n, phload_n, src, qpsk, gate_n, preset_n, half, tstep_n, bypass_n} = 12'h792;
    fails = 0;
    checks = 0;
    tick(3);
    arst_n <= 1'b1;
    tick(3);
    load(32'h12345678, 0);
    load(32'h00010001, 1);
    i_nco_host_model.write(SEL_PHASE, 16'h0100, 1'b0);
    phload_n <= 1'b0;
    tick(8);
    chk("bypass sine", 16'h1335, sin_out);
    chk("bypass cosine", 16'h5679, cos_out);
    gate_n <= 1'b0;
    tick(6);
    chk("gated cosine", 16'h5678, cos_out);
    i_nco_host_model.write(2'h3, 16'hffff, 1'b0);
    i_nco_host_model.write(SEL_PHASE, 16'hffff, 1'b1);
    center_n <= 1'b0;
    tick(1);
    center_n <= 1'b1;
    tick(8);
    chk("reserved sine", 16'h0101, sin_out);
    chk("reserved cosine", 16'h0001, cos_out);
    src <= 1'b0;
    for (n = 0; n < 4; n++) begin
      qpsk <= n[1:0];
      tick(8);
      chk("symbol sine", 16'h0001 + shift_q[n], sin_out);
    end
    half <= 1'b1;
    tick(6);
    chk("half circle sine", 16'h0001, sin_out);
    half <= 1'b0;
    qpsk <= 2'h0;
    preset_n <= 1'b1;
    load(32'h40000000, 0);
    count_low(1'b0, 16'h0008);
    bypass_n <= 1'b1;
    load(32'h20000000, 2);
    count_low(1'b1, 16'h0004);
    bypass_n <= 1'b0;
    tick(2);
    count_low(1'b1, 16'h0000);
    bypass_n <= 1'b1;
    preset_n <= 1'b0;
    load(32'h00000000, 0);
    for (n = 0; n < 3; n++) begin
      qpsk <= n[1:0];
      tick(24);
      chk("sine", sin_q[n], sin_out, 4);
      chk("cosine", cos_q[n], cos_out, 4);
    end
    end_of_test();
  end
endmodule // test_nco_phase_freq_sincos
